// file: loop_ctrl_pkg.sv
// constants, register map and carrier structs for the system loop controller
package loop_ctrl_pkg;
    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_MULT = 8'h04;
    localparam logic [7:0] OFS_DIV1 = 8'h08;
    localparam logic [7:0] OFS_DIV2 = 8'h0C;
    localparam logic [7:0] OFS_DIV3 = 8'h10;
    localparam logic [7:0] OFS_COMMAND = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_OSC_DIV = 8'h1C;
    localparam logic [7:0] OFS_BP_DIV = 8'h20;
    // ****************************************
    // field positions
    // ****************************************
    localparam int CTL_SELECT_BIT = 0;
    localparam int CTL_SOURCE_BIT = 1;
    localparam int CTL_RESET_N_BIT = 3;
    localparam int CTL_DISABLE_BIT = 4;
    localparam int CTL_PWRDN_BIT = 5;
    localparam int CTL_REFKIND_BIT = 8;
    localparam int DIV_EN_BIT = 15;
    localparam int CMD_GO_BIT = 0;
    localparam int STAT_GO_BIT = 0;
    localparam int STAT_MODE_BIT = 1;
    localparam int STAT_STRAP_BIT = 2;
    localparam int RATIO_W = 5;
    localparam int MULT_W = 5;
    // ****************************************
    // values after reset
    // ****************************************
    localparam logic [RATIO_W-1:0] DIV1_RST = 5'h00;
    localparam logic [RATIO_W-1:0] DIV2_RST = 5'h02;
    localparam logic [RATIO_W-1:0] DIV3_RST = 5'h05;
    localparam logic [RATIO_W-1:0] OSC_DIV_RST = 5'h00;
    localparam logic [RATIO_W-1:0] BP_DIV_RST = 5'h00;
    localparam logic [MULT_W-1:0] MULT_RST = 5'h00;
    // ****************************************
    // timing, in reference input cycles
    // ****************************************
    localparam int BYPASS_SWITCH_MAX = 4;
    localparam logic [1:0] BYPASS_SWITCH_CYC = 2'(BYPASS_SWITCH_MAX - 2);
    // edges after reset release before the strap sync chain holds the pin level
    localparam logic [1:0] STRAP_SETTLE_CYC = 2'h3;
    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bus_req_s;
    typedef struct packed {
        logic power_down;
        logic reset_n;
        logic output_disable;
        logic [MULT_W-1:0] mult;
    } loop_pins_s;
    typedef enum logic [0:0] {GO_IDLE, GO_ALIGN} go_state_e;
    typedef enum logic [1:0] {BOOT_CHECK, BOOT_LOCK, BOOT_DONE} boot_state_e;
endpackage

// file: system_loop_controller.sv
// system loop controller: bypass/loop selection, loop pin control and domain clock dividers
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module system_loop_controller (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // register port
    input wire loop_ctrl_pkg::bus_req_s bus_req,
    output logic [31:0] rdata,
    // analog loop interface
    output loop_ctrl_pkg::loop_pins_s loop_pins,
    input wire logic loop_tick,
    input wire logic loop_locked,
    output logic reference_kind_select,
    // strap
    input wire logic quick_boot_strap,
    // clock outputs, one tick per divided period
    output logic [2:0] domain_clock,
    output logic auxiliary_reference_clock,
    output logic observe_clock,
    output logic bypass_domain_clock
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [2:0] strap_sync;
        logic [1:0] lock_sync;
        logic strap_seen;
        logic select;
        logic source;
        logic reset_n;
        logic out_disable;
        logic power_down;
        logic ref_kind;
        logic [loop_ctrl_pkg::MULT_W-1:0] mult;
        logic [2:0] div_en;
        logic [2:0][loop_ctrl_pkg::RATIO_W-1:0] ratio;
        logic [2:0][loop_ctrl_pkg::RATIO_W-1:0] act;
        logic [2:0][loop_ctrl_pkg::RATIO_W-1:0] cnt;
        logic [1:0] osc_en_bp_en;
        logic [1:0][loop_ctrl_pkg::RATIO_W-1:0] aux_ratio;
        logic [1:0][loop_ctrl_pkg::RATIO_W-1:0] aux_cnt;
        logic mode;
        logic [1:0] sw_cnt;
        logic go_status;
        loop_ctrl_pkg::go_state_e go_state;
        loop_ctrl_pkg::boot_state_e boot_state;
        logic [1:0] boot_wait;
        logic [2:0] dclk;
        logic [1:0] aclk;
        logic [31:0] rdata;
    } state_s;

    state_s st_r;
    state_s st_nxt;
    logic path_eff;
    logic src_tick;
    logic aligned;

    // wrapping divide counter step
    function automatic logic [loop_ctrl_pkg::RATIO_W-1:0] step(
        input logic [loop_ctrl_pkg::RATIO_W-1:0] c,
        input logic [loop_ctrl_pkg::RATIO_W-1:0] r);
        step = (c >= r) ? '0 : c + 5'h01;
    endfunction

    assign path_eff = st_r.select & ~st_r.source;
    // loop edges pass only in loop mode, gated by disable, power-down and loop reset
    assign src_tick = st_r.mode ? (loop_tick & ~st_r.out_disable & ~st_r.power_down & st_r.reset_n) : 1'b1;
    assign aligned = (st_r.cnt[0] == '0) && (st_r.cnt[1] == '0) && (st_r.cnt[2] == '0);

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        // strap and lock come from outside: three flops for strap, two for lock before use
        st_nxt.strap_sync = {st_r.strap_sync[1:0], quick_boot_strap};
        st_nxt.lock_sync = {st_r.lock_sync[0], loop_locked};
        st_nxt.dclk = '0;
        st_nxt.aclk = '0;
        st_nxt.rdata = '0;

        // mode follows the effective select after a short settle
        if (st_r.mode != path_eff) begin
            st_nxt.sw_cnt = st_r.sw_cnt + 2'h1;
            if (st_r.sw_cnt >= loop_ctrl_pkg::BYPASS_SWITCH_CYC) begin
                st_nxt.mode = path_eff;
                st_nxt.sw_cnt = '0;
            end
        end else begin
            st_nxt.sw_cnt = '0;
        end

        // domain dividers, paused on cycles without a source tick
        for (int i = 0; i < 3; i++) begin
            if (src_tick) begin
                st_nxt.cnt[i] = step(st_r.cnt[i], st_r.act[i]);
                // a cleared enable holds the domain output low
                st_nxt.dclk[i] = (st_r.cnt[i] == '0) & st_r.div_en[i];
            end
        end

        // observe and bypass domain dividers run on the reference
        for (int j = 0; j < 2; j++) begin
            st_nxt.aux_cnt[j] = step(st_r.aux_cnt[j], st_r.aux_ratio[j]);
            st_nxt.aclk[j] = (st_r.aux_cnt[j] == '0) & st_r.osc_en_bp_en[j];
        end

        // at the aligned point the new ratios load; that tick is dropped
        case (st_r.go_state)
            loop_ctrl_pkg::GO_IDLE: begin
            end
            loop_ctrl_pkg::GO_ALIGN: begin
                if (src_tick && aligned) begin
                    st_nxt.act = st_r.ratio;
                    st_nxt.cnt = '0;
                    st_nxt.dclk = '0;
                    // status clears once ratios are applied
                    st_nxt.go_status = 1'b0;
                    st_nxt.go_state = loop_ctrl_pkg::GO_IDLE;
                end
            end
            default: st_nxt.go_state = loop_ctrl_pkg::GO_IDLE;
        endcase

        // register writes
        if (bus_req.wr) begin
            case (bus_req.addr)
                loop_ctrl_pkg::OFS_CONTROL: begin
                    st_nxt.select = bus_req.wdata[loop_ctrl_pkg::CTL_SELECT_BIT];
                    st_nxt.source = bus_req.wdata[loop_ctrl_pkg::CTL_SOURCE_BIT];
                    st_nxt.reset_n = bus_req.wdata[loop_ctrl_pkg::CTL_RESET_N_BIT];
                    st_nxt.out_disable = bus_req.wdata[loop_ctrl_pkg::CTL_DISABLE_BIT];
                    st_nxt.power_down = bus_req.wdata[loop_ctrl_pkg::CTL_PWRDN_BIT];
                    st_nxt.ref_kind = bus_req.wdata[loop_ctrl_pkg::CTL_REFKIND_BIT];
                end
                loop_ctrl_pkg::OFS_MULT: begin
                    // factor only accepted with loop in reset and in bypass
                    if (!st_r.reset_n && !st_r.mode) begin
                        st_nxt.mult = bus_req.wdata[loop_ctrl_pkg::MULT_W-1:0];
                    end
                end
                loop_ctrl_pkg::OFS_DIV1, loop_ctrl_pkg::OFS_DIV2, loop_ctrl_pkg::OFS_DIV3: begin
                    for (int k = 0; k < 3; k++) begin
                        if (bus_req.addr == 8'(loop_ctrl_pkg::OFS_DIV1 + 8'(4 * k))) begin
                            st_nxt.ratio[k] = bus_req.wdata[loop_ctrl_pkg::RATIO_W-1:0];
                            st_nxt.div_en[k] = bus_req.wdata[loop_ctrl_pkg::DIV_EN_BIT];
                        end
                    end
                end
                loop_ctrl_pkg::OFS_COMMAND: begin
                    // go set starts a transition; a second go while busy is ignored
                    if (bus_req.wdata[loop_ctrl_pkg::CMD_GO_BIT] && st_r.go_state == loop_ctrl_pkg::GO_IDLE) begin
                        st_nxt.go_status = 1'b1;
                        st_nxt.go_state = loop_ctrl_pkg::GO_ALIGN;
                    end
                end
                loop_ctrl_pkg::OFS_OSC_DIV: begin
                    st_nxt.aux_ratio[0] = bus_req.wdata[loop_ctrl_pkg::RATIO_W-1:0];
                    st_nxt.osc_en_bp_en[0] = bus_req.wdata[loop_ctrl_pkg::DIV_EN_BIT];
                end
                loop_ctrl_pkg::OFS_BP_DIV: begin
                    st_nxt.aux_ratio[1] = bus_req.wdata[loop_ctrl_pkg::RATIO_W-1:0];
                    st_nxt.osc_en_bp_en[1] = bus_req.wdata[loop_ctrl_pkg::DIV_EN_BIT];
                end
                default: begin
                end
            endcase
        end

        // register reads, answered the next cycle; unmapped reads give zero
        if (bus_req.rd) begin
            case (bus_req.addr)
                loop_ctrl_pkg::OFS_CONTROL: begin
                    st_nxt.rdata[loop_ctrl_pkg::CTL_SELECT_BIT] = st_r.select;
                    st_nxt.rdata[loop_ctrl_pkg::CTL_SOURCE_BIT] = st_r.source;
                    st_nxt.rdata[loop_ctrl_pkg::CTL_RESET_N_BIT] = st_r.reset_n;
                    st_nxt.rdata[loop_ctrl_pkg::CTL_DISABLE_BIT] = st_r.out_disable;
                    st_nxt.rdata[loop_ctrl_pkg::CTL_PWRDN_BIT] = st_r.power_down;
                    st_nxt.rdata[loop_ctrl_pkg::CTL_REFKIND_BIT] = st_r.ref_kind;
                end
                loop_ctrl_pkg::OFS_MULT: st_nxt.rdata[loop_ctrl_pkg::MULT_W-1:0] = st_r.mult;
                loop_ctrl_pkg::OFS_DIV1, loop_ctrl_pkg::OFS_DIV2, loop_ctrl_pkg::OFS_DIV3: begin
                    for (int k = 0; k < 3; k++) begin
                        if (bus_req.addr == 8'(loop_ctrl_pkg::OFS_DIV1 + 8'(4 * k))) begin
                            st_nxt.rdata[loop_ctrl_pkg::RATIO_W-1:0] = st_r.ratio[k];
                            st_nxt.rdata[loop_ctrl_pkg::DIV_EN_BIT] = st_r.div_en[k];
                        end
                    end
                end
                // status shows transition in progress, the live mode and the strap seen at boot
                loop_ctrl_pkg::OFS_STATUS: begin
                    st_nxt.rdata[loop_ctrl_pkg::STAT_GO_BIT] = st_r.go_status;
                    st_nxt.rdata[loop_ctrl_pkg::STAT_MODE_BIT] = st_r.mode;
                    st_nxt.rdata[loop_ctrl_pkg::STAT_STRAP_BIT] = st_r.strap_seen;
                end
                loop_ctrl_pkg::OFS_OSC_DIV: begin
                    st_nxt.rdata[loop_ctrl_pkg::RATIO_W-1:0] = st_r.aux_ratio[0];
                    st_nxt.rdata[loop_ctrl_pkg::DIV_EN_BIT] = st_r.osc_en_bp_en[0];
                end
                loop_ctrl_pkg::OFS_BP_DIV: begin
                    st_nxt.rdata[loop_ctrl_pkg::RATIO_W-1:0] = st_r.aux_ratio[1];
                    st_nxt.rdata[loop_ctrl_pkg::DIV_EN_BIT] = st_r.osc_en_bp_en[1];
                end
                default: st_nxt.rdata = '0;
            endcase
        end

        // quick boot: strap caught after release, loop brought up and selected
        case (st_r.boot_state)
            loop_ctrl_pkg::BOOT_CHECK: begin
                // the sync chain restarts from zero at reset, so wait until it has filled
                st_nxt.boot_wait = st_r.boot_wait + 2'h1;
                if (st_r.boot_wait == loop_ctrl_pkg::STRAP_SETTLE_CYC) begin
                    st_nxt.strap_seen = st_r.strap_sync[2];
                    st_nxt.power_down = st_r.strap_sync[2] ? 1'b0 : st_nxt.power_down;
                    st_nxt.out_disable = st_r.strap_sync[2] ? 1'b0 : st_nxt.out_disable;
                    st_nxt.reset_n = st_r.strap_sync[2] ? 1'b1 : st_nxt.reset_n;
                    st_nxt.boot_state = st_r.strap_sync[2] ? loop_ctrl_pkg::BOOT_LOCK : loop_ctrl_pkg::BOOT_DONE;
                end
            end
            loop_ctrl_pkg::BOOT_LOCK: begin
                if (st_r.lock_sync[1]) begin
                    st_nxt.source = 1'b0;
                    st_nxt.select = 1'b1;
                    st_nxt.boot_state = loop_ctrl_pkg::BOOT_DONE;
                end
            end
            loop_ctrl_pkg::BOOT_DONE: begin
            end
            default: st_nxt.boot_state = loop_ctrl_pkg::BOOT_DONE;
        endcase
    end

    // ****************************************
    // registers
    // ****************************************
    // power-up leaves the loop down, disabled, in reset, bypass selected
    // any device reset lands here again
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.source <= 1'b1;
            st_r.out_disable <= 1'b1;
            st_r.power_down <= 1'b1;
            st_r.mult <= loop_ctrl_pkg::MULT_RST;
            st_r.div_en <= 3'h7;
            st_r.ratio <= {loop_ctrl_pkg::DIV3_RST, loop_ctrl_pkg::DIV2_RST, loop_ctrl_pkg::DIV1_RST};
            st_r.act <= {loop_ctrl_pkg::DIV3_RST, loop_ctrl_pkg::DIV2_RST, loop_ctrl_pkg::DIV1_RST};
            st_r.osc_en_bp_en <= 2'h3;
            st_r.aux_ratio <= {loop_ctrl_pkg::BP_DIV_RST, loop_ctrl_pkg::OSC_DIV_RST};
            st_r.go_state <= loop_ctrl_pkg::GO_IDLE;
            st_r.boot_state <= loop_ctrl_pkg::BOOT_CHECK;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from flops, except the auxiliary reference tied high
    assign rdata = st_r.rdata;
    assign loop_pins = '{power_down: st_r.power_down, reset_n: st_r.reset_n,
                         output_disable: st_r.out_disable, mult: st_r.mult};
    assign reference_kind_select = st_r.ref_kind;
    assign domain_clock = st_r.dclk;
    assign observe_clock = st_r.aclk[0];
    assign bypass_domain_clock = st_r.aclk[1];
    // undivided reference, one tick every cycle, in reset too
    assign auxiliary_reference_clock = st_r.osc_en_bp_en[0] | st_r.osc_en_bp_en[1] | 1'b1;

    // ****************************************
    // checks
    // ****************************************
    sequence seq_go_req;
        bus_req.wr && bus_req.addr == loop_ctrl_pkg::OFS_COMMAND && bus_req.wdata[0] && !st_r.go_status;
    endsequence
    sequence seq_go_apply;
        st_r.go_status && src_tick && aligned;
    endsequence

    property p_pd_write;
        @(posedge sys_clk) disable iff (!rst_n)
        bus_req.wr && bus_req.addr == loop_ctrl_pkg::OFS_CONTROL && st_r.boot_state == loop_ctrl_pkg::BOOT_DONE
        |=> loop_pins.power_down == $past(bus_req.wdata[5]) && loop_pins.reset_n == $past(bus_req.wdata[3]);
    endproperty
    a_pd_write: assert property (p_pd_write) else $error("loop pin not following control write");
    property p_bypass_deadline;
        @(posedge sys_clk) disable iff (!rst_n)
        $fell(path_eff) |-> ##[1:4] !st_r.mode;
    endproperty
    a_bypass_deadline: assert property (p_bypass_deadline) else $error("bypass not reached in time");
    property p_source_forces;
        @(posedge sys_clk) disable iff (!rst_n)
        st_r.source [*4] |-> !st_r.mode;
    endproperty
    a_source_forces: assert property (p_source_forces) else $error("loop mode while source bit set");
    property p_bypass_src;
        @(posedge sys_clk) disable iff (!rst_n)
        (!st_r.mode |-> src_tick) and (st_r.mode && st_r.out_disable |-> !src_tick);
    endproperty
    a_bypass_src: assert property (p_bypass_src) else $error("divider source wrong for mode");
    property p_go_start;
        @(posedge sys_clk) disable iff (!rst_n)
        seq_go_req |=> st_r.go_status && st_r.go_state == loop_ctrl_pkg::GO_ALIGN;
    endproperty
    a_go_start: assert property (p_go_start) else $error("go write did not raise status");
    property p_go_apply;
        @(posedge sys_clk) disable iff (!rst_n)
        seq_go_apply |=> !st_r.go_status && domain_clock == 3'h0 && st_r.act == $past(st_r.ratio);
    endproperty
    a_go_apply: assert property (p_go_apply) else $error("ratios not applied at alignment");
    property p_div_enable;
        @(posedge sys_clk) disable iff (!rst_n)
        !st_r.div_en[2] |=> !domain_clock[2];
    endproperty
    a_div_enable: assert property (p_div_enable) else $error("disabled divider still ticks");
    property p_mult_guard;
        @(posedge sys_clk) disable iff (!rst_n)
        bus_req.wr && bus_req.addr == loop_ctrl_pkg::OFS_MULT && st_r.reset_n |=> $stable(loop_pins.mult);
    endproperty
    a_mult_guard: assert property (p_mult_guard) else $error("multiplier changed out of reset");
    property p_div1_rate;
        @(posedge sys_clk) disable iff (!rst_n)
        !st_r.mode && st_r.act[0] == '0 && st_r.div_en[0] && !st_r.go_status ##1 !st_r.go_status |-> domain_clock[0];
    endproperty
    a_div1_rate: assert property (p_div1_rate) else $error("divide by one missed a tick");
endmodule

// file: testbench.sv
// self-checking testbench for the system loop controller
`timescale 1ns/1ps
module testbench;
    logic sys_clk, rst_n, loop_tick, loop_locked, quick_boot_strap, reference_kind_select;
    logic auxiliary_reference_clock, observe_clock, bypass_domain_clock;
    loop_ctrl_pkg::bus_req_s bus_req;
    loop_ctrl_pkg::loop_pins_s loop_pins;
    logic [31:0] rdata, rv;
    logic [2:0] domain_clock;
    int fails, total_checks, k, ones;
    int cnt [5];
    system_loop_controller u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
        .loop_pins(loop_pins), .loop_tick(loop_tick), .loop_locked(loop_locked),
        .reference_kind_select(reference_kind_select), .quick_boot_strap(quick_boot_strap),
        .domain_clock(domain_clock), .auxiliary_reference_clock(auxiliary_reference_clock),
        .observe_clock(observe_clock), .bypass_domain_clock(bypass_domain_clock));
    // ****************************************
    // clock, compare and bus helpers
    // ****************************************
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask
    // one-cycle write strobe, then an idle edge so strobes never overlap
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.wr <= 1'b1;
        @(posedge sys_clk);
        bus_req.wr <= 1'b0;
        // let the launching edge settle before anyone looks at the outputs
        #1;
    endtask
    // read data stand only in the cycle after the strobe
    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge sys_clk);
        bus_req.rd <= 1'b0;
        #1 d = rdata;
    endtask
    // counts ticks of the domain, observe and bypass outputs; loop ticks are random for the first nr cycles only
    task count(input int n, input int nr);
        bit t;
        ones = 0;
        foreach (cnt[i]) cnt[i] = 0;
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            t = (i < nr) ? 1'($urandom_range(0, 1)) : 1'b0;
            loop_tick <= t;
            ones += int'(t);
            #1 for (int j = 0; j < 3; j++) cnt[j] += int'(domain_clock[j]);
            cnt[3] += int'(observe_clock);
            cnt[4] += int'(bypass_domain_clock);
            chk({31'h0, auxiliary_reference_clock}, 32'h1);
        end
    endtask
    task wrap_up;
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // hang guard: all tests take well under two thousand cycles
    initial begin
        #100000;
        fails++;
        wrap_up();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rst_n = 1'b0;
        bus_req = '0;
        loop_tick = 1'b0;
        loop_locked = 1'b0;
        quick_boot_strap = 1'b0;
        fails = 0;
        total_checks = 0;
        void'($urandom(28073));
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        chk({24'h0, loop_pins}, 32'h000000A0);
        rd(loop_ctrl_pkg::OFS_CONTROL, rv);
        chk(rv, 32'h00000032);
        rd(loop_ctrl_pkg::OFS_DIV1, rv);
        chk(rv, 32'h00008000);
        rd(loop_ctrl_pkg::OFS_DIV3, rv);
        chk(rv, 32'h00008005);
        rd(8'h24, rv);
        chk(rv, 32'h00000000);
        count(24, 0);
        chk(cnt[0], 32'h18);
        chk(cnt[1], 32'h8);
        chk(cnt[2], 32'h4);
        chk(cnt[3], 32'h18);
        chk(cnt[4], 32'h18);
        $display("test reset defaults done");
        // bring-up: reference kind, bypass, then loop pins step by step
        // full bring-up order from power-down
        // no other traffic while the loop frequency changes
        wr(loop_ctrl_pkg::OFS_CONTROL, 32'h00000130);
        chk({31'h0, reference_kind_select}, 32'h1);
        wr(loop_ctrl_pkg::OFS_CONTROL, 32'h00000110);
        chk({24'h0, loop_pins}, 32'h00000020);
        wr(loop_ctrl_pkg::OFS_CONTROL, 32'h00000100);
        k = $urandom_range(1, 31);
        wr(loop_ctrl_pkg::OFS_MULT, 32'(k));
        chk({24'h0, loop_pins}, 32'(k));
        wr(loop_ctrl_pkg::OFS_CONTROL, 32'h00000108);
        wr(loop_ctrl_pkg::OFS_MULT, 32'(k ^ 1));
        chk({24'h0, loop_pins}, 32'h40 | 32'(k));
        loop_locked <= 1'b1;
        wr(loop_ctrl_pkg::OFS_CONTROL, 32'h00000109);
        repeat (4) @(posedge sys_clk);
        rd(loop_ctrl_pkg::OFS_STATUS, rv);
        chk({31'h0, rv[1]}, 32'h1);
        count(40, 36);
        chk(cnt[0], ones);
        wr(loop_ctrl_pkg::OFS_CONTROL, 32'h00000119);
        count(40, 36);
        chk(cnt[0], 0);
        // back to bypass before touching the loop again
        wr(loop_ctrl_pkg::OFS_CONTROL, 32'h00000108);
        repeat (4) @(posedge sys_clk);
        rd(loop_ctrl_pkg::OFS_STATUS, rv);
        chk({31'h0, rv[1]}, 32'h0);
        count(12, 12);
        chk(cnt[0], 12);
        wr(loop_ctrl_pkg::OFS_CONTROL, 32'h0000010B);
        repeat (4) @(posedge sys_clk);
        rd(loop_ctrl_pkg::OFS_STATUS, rv);
        chk({31'h0, rv[1]}, 32'h0);
        $display("test bring-up and mode done");
        // divider change keeping 1:3:6, plus observe and bypass dividers
        k = $urandom_range(1, 5);
        // ratios keep 1:3:6, enables left set
        wr(loop_ctrl_pkg::OFS_DIV1, 32'h8000 | 32'(k - 1));
        wr(loop_ctrl_pkg::OFS_DIV2, 32'h8000 | 32'(3 * k - 1));
        wr(loop_ctrl_pkg::OFS_DIV3, 32'h8000 | 32'(6 * k - 1));
        wr(loop_ctrl_pkg::OFS_OSC_DIV, 32'h00008003);
        wr(loop_ctrl_pkg::OFS_BP_DIV, 32'h00008001);
        wr(loop_ctrl_pkg::OFS_COMMAND, 32'h00000001);
        rv = 32'h1;
        // old divisors /1 /3 /6 align within 6 source cycles; poll status up to 2*6+50 times
        for (int i = 0; i < 62 && rv[0] === 1'b1; i++) rd(loop_ctrl_pkg::OFS_STATUS, rv);
        chk({31'h0, rv[0]}, 32'h0);
        rd(loop_ctrl_pkg::OFS_COMMAND, rv);
        chk(rv, 32'h0);
        rd(loop_ctrl_pkg::OFS_DIV2, rv);
        chk(rv, 32'h8000 | 32'(3 * k - 1));
        count(24 * k, 0);
        chk(cnt[0], 32'h18);
        chk(cnt[1], 32'h8);
        chk(cnt[2], 32'h4);
        chk(cnt[3], 32'(6 * k));
        chk(cnt[4], 32'(12 * k));
        // a cleared enable silences the third domain
        wr(loop_ctrl_pkg::OFS_DIV3, 32'(6 * k - 1));
        count(12 * k, 0);
        chk(cnt[2], 32'h0);
        chk(cnt[1], 32'h4);
        $display("test divider change done");
        // a second reset mid-run powers the loop down again, then quick boot brings it up
        quick_boot_strap <= 1'b1;
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk({24'h0, loop_pins}, 32'h000000A0);
        rst_n <= 1'b1;
        repeat (20) @(posedge sys_clk);
        rd(loop_ctrl_pkg::OFS_STATUS, rv);
        chk(rv, 32'h00000006);
        chk({24'h0, loop_pins}, 32'h00000040);
        $display("test mid-run reset done");
        wrap_up();
    end
endmodule
